// file: dgp_pkg.sv
package dgp_pkg;

  // Port and group geometry
  localparam int DGP_PORT_W = 8;
  localparam int DGP_DATA_W = 16;
  localparam int DGP_NUM_GRP = 2;
  localparam int DGP_NUM_PORT = 4;
  localparam int DGP_NUM_CNT = 3;

  // Base-address compare uses the upper five of the ten decoded lines
  localparam int DGP_ADDR_W = 10;
  localparam int DGP_SEL_LSB = 5;
  localparam int DGP_IDX_W = 5;

  // Register indices within the board window
  localparam logic [4:0] DGP_REG_G1_DATA = 5'h00;
  localparam logic [4:0] DGP_REG_G2_DATA = 5'h01;
  localparam logic [4:0] DGP_REG_G1_CFG = 5'h02;
  localparam logic [4:0] DGP_REG_G2_CFG = 5'h03;
  localparam logic [4:0] DGP_REG_CNT_CFG = 5'h04;
  localparam logic [4:0] DGP_REG_CNT1_LOAD = 5'h05;
  localparam logic [4:0] DGP_REG_CNT2_LOAD = 5'h06;
  localparam logic [4:0] DGP_REG_CNT3_LOAD = 5'h07;
  localparam logic [4:0] DGP_REG_STATUS = 5'h08;

  // Group configuration fields
  localparam int DGP_GCFG_LO_WRITE = 0;
  localparam int DGP_GCFG_HI_WRITE = 1;
  localparam int DGP_GCFG_LO_DBL = 2;
  localparam int DGP_GCFG_HI_DBL = 3;
  localparam int DGP_GCFG_REQ_FALL = 4;
  localparam int DGP_GCFG_W = 5;
  localparam logic [4:0] DGP_GCFG_RST = 5'h00;

  // Counter configuration fields
  localparam int DGP_CCFG_SRC_TRIG = 0;
  localparam int DGP_CCFG_C1_DIRECT = 1;
  localparam int DGP_CCFG_C2_DIRECT = 2;
  localparam int DGP_CCFG_C1_REQ = 3;
  localparam int DGP_CCFG_C2_REQ = 4;
  localparam int DGP_CCFG_C3_IRQ = 5;
  localparam int DGP_CCFG_C1_RUN = 6;
  localparam int DGP_CCFG_W = 9;
  localparam logic [8:0] DGP_CCFG_RST = 9'h000;

  // Status fields
  localparam int DGP_STAT_READY1 = 0;
  localparam int DGP_STAT_C3_FLAG = 2;
  localparam int DGP_STAT_ACK1 = 3;

  // Counter time base
  localparam logic [2:0] DGP_CLK_DIV = 3'h5;
  localparam logic [15:0] DGP_LOAD_RST = 16'hFFFF;

  // Handshake state per group
  typedef enum logic [1:0] {
    DGP_HS_WAIT = 2'b01,
    DGP_HS_ACK = 2'b10
  } dgp_hs_t;

endpackage

// file: dgp_io.sv
`timescale 1ns/1ps
module dgp_io
  import dgp_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [9:0] SA,
  input wire logic [4:0] BASE_ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [15:0] RD_DATA,
  output logic BUS_WIDTH_16,
  input wire logic [7:0] PORT_A_LINES_IN,
  output logic [7:0] PORT_A_LINES_OUT,
  output logic [7:0] PORT_A_LINES_OE,
  input wire logic [7:0] PORT_B_LINES_IN,
  output logic [7:0] PORT_B_LINES_OUT,
  output logic [7:0] PORT_B_LINES_OE,
  input wire logic [7:0] PORT_C_LINES_IN,
  output logic [7:0] PORT_C_LINES_OUT,
  output logic [7:0] PORT_C_LINES_OE,
  input wire logic [7:0] PORT_D_LINES_IN,
  output logic [7:0] PORT_D_LINES_OUT,
  output logic [7:0] PORT_D_LINES_OE,
  input wire logic GROUP_ONE_REQUEST,
  input wire logic GROUP_TWO_REQUEST,
  output logic GROUP_ONE_ACK,
  output logic GROUP_TWO_ACK,
  input wire logic ONBOARD_OSCILLATOR,
  input wire logic SHARED_TRIGGER_BUS_CLOCK,
  output logic PERIODIC_IRQ
);

  // Value a host read sees for one port
  function automatic logic [7:0] port_value(input logic wr, input logic dbl,
                                            input logic [7:0] drive, input logic [7:0] latch,
                                            input logic [7:0] live);
    if (wr) begin
      port_value = drive;
    end else if (dbl) begin
      port_value = latch;
    end else begin
      port_value = live;
    end
  endfunction

  // Down count with reload; top bit flags the terminal count
  function automatic logic [16:0] cnt_step(input logic [15:0] cnt, input logic [15:0] load);
    if (cnt == 16'h0000) begin
      cnt_step = {1'b1, load};
    end else begin
      cnt_step = {1'b0, cnt - 16'h0001};
    end
  endfunction

  // Bus decode
  logic sel;
  logic [4:0] idx;
  logic wr_hit;
  logic rd_hit;
  assign sel = (SA[DGP_ADDR_W-1:DGP_SEL_LSB] == BASE_ADDR);
  assign idx = SA[DGP_IDX_W-1:0];
  assign wr_hit = WR_STB && sel;
  assign rd_hit = RD_STB && sel;

  // Configuration and bus answer state
  logic [4:0] gcfg_reg [DGP_NUM_GRP];
  logic [4:0] gcfg_next [DGP_NUM_GRP];
  logic [8:0] ccfg_reg;
  logic [8:0] ccfg_next;
  logic [15:0] load_reg [DGP_NUM_CNT];
  logic [15:0] load_next [DGP_NUM_CNT];
  logic c3flag_reg;
  logic c3flag_next;
  logic [15:0] rd_data_reg;
  logic [15:0] rd_data_next;
  logic bw16_reg;
  logic bw16_next;

  // Handshake and data path state
  dgp_hs_t hs_reg [DGP_NUM_GRP];
  dgp_hs_t hs_next [DGP_NUM_GRP];
  logic ready_reg [DGP_NUM_GRP];
  logic ready_next [DGP_NUM_GRP];
  logic ack_reg [DGP_NUM_GRP];
  logic ack_next [DGP_NUM_GRP];
  logic reqp_reg [DGP_NUM_GRP];
  logic reqp_next [DGP_NUM_GRP];
  logic [7:0] stage_reg [DGP_NUM_PORT];
  logic [7:0] stage_next [DGP_NUM_PORT];
  logic [7:0] drive_reg [DGP_NUM_PORT];
  logic [7:0] drive_next [DGP_NUM_PORT];
  logic [7:0] latch_reg [DGP_NUM_PORT];
  logic [7:0] latch_next [DGP_NUM_PORT];

  // Counter state
  logic src_reg;
  logic src_next;
  logic srcp_reg;
  logic srcp_next;
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic [15:0] cnt_reg [DGP_NUM_CNT];
  logic [15:0] cnt_next [DGP_NUM_CNT];
  logic pulse_reg [DGP_NUM_CNT];
  logic pulse_next [DGP_NUM_CNT];

  // Shared combinational terms
  logic [7:0] live [DGP_NUM_PORT];
  logic req_pin [DGP_NUM_GRP];
  logic req_evt [DGP_NUM_GRP];
  logic grp_write [DGP_NUM_GRP];
  logic data_rd [DGP_NUM_GRP];
  logic data_wr [DGP_NUM_GRP];
  logic cclk_tick;
  logic c3_tick;
  logic tick [DGP_NUM_CNT];

  assign live[0] = PORT_A_LINES_IN;
  assign live[1] = PORT_B_LINES_IN;
  assign live[2] = PORT_C_LINES_IN;
  assign live[3] = PORT_D_LINES_IN;
  assign req_pin[0] = GROUP_ONE_REQUEST;
  assign req_pin[1] = GROUP_TWO_REQUEST;

  // Request events, one per group; the counter path lets pattern generation run unattended
  always_comb begin
    for (int g = 0; g < DGP_NUM_GRP; g++) begin
      grp_write[g] = gcfg_reg[g][DGP_GCFG_LO_WRITE] | gcfg_reg[g][DGP_GCFG_HI_WRITE];
      data_rd[g] = rd_hit && (idx == (DGP_REG_G1_DATA + 5'(g)));
      data_wr[g] = wr_hit && (idx == (DGP_REG_G1_DATA + 5'(g)));
      reqp_next[g] = req_pin[g];
      req_evt[g] = gcfg_reg[g][DGP_GCFG_REQ_FALL] ? (reqp_reg[g] & ~req_pin[g])
                                                  : (req_pin[g] & ~reqp_reg[g]);
      if (pulse_reg[g] && ccfg_reg[DGP_CCFG_C1_REQ + g]) begin
        req_evt[g] = 1'b1;
      end
    end
  end

  // Bus registers and read answer
  always_comb begin
    for (int g = 0; g < DGP_NUM_GRP; g++) begin
      gcfg_next[g] = gcfg_reg[g];
    end
    for (int c = 0; c < DGP_NUM_CNT; c++) begin
      load_next[c] = load_reg[c];
    end
    ccfg_next = ccfg_reg;
    rd_data_next = 16'h0000;
    bw16_next = wr_hit || rd_hit;
    // Set wins over a same-cycle clear so no counter event is lost
    c3flag_next = c3flag_reg;
    if (wr_hit && idx == DGP_REG_STATUS && WR_DATA[DGP_STAT_C3_FLAG]) begin
      c3flag_next = 1'b0;
    end
    if (pulse_reg[2] && ccfg_reg[DGP_CCFG_C3_IRQ]) begin
      c3flag_next = 1'b1;
    end
    if (wr_hit) begin
      case (idx)
        DGP_REG_G1_CFG: gcfg_next[0] = WR_DATA[DGP_GCFG_W-1:0];
        DGP_REG_G2_CFG: gcfg_next[1] = WR_DATA[DGP_GCFG_W-1:0];
        DGP_REG_CNT_CFG: ccfg_next = WR_DATA[DGP_CCFG_W-1:0];
        DGP_REG_CNT1_LOAD: load_next[0] = WR_DATA;
        DGP_REG_CNT2_LOAD: load_next[1] = WR_DATA;
        DGP_REG_CNT3_LOAD: load_next[2] = WR_DATA;
        default: ;
      endcase
    end
    if (rd_hit) begin
      case (idx)
        DGP_REG_G1_DATA, DGP_REG_G2_DATA: begin
          for (int g = 0; g < DGP_NUM_GRP; g++) begin
            if (idx == (DGP_REG_G1_DATA + 5'(g))) begin
              rd_data_next = {port_value(gcfg_reg[g][DGP_GCFG_HI_WRITE],
                                         gcfg_reg[g][DGP_GCFG_HI_DBL], drive_reg[2*g+1],
                                         latch_reg[2*g+1], live[2*g+1]),
                              port_value(gcfg_reg[g][DGP_GCFG_LO_WRITE],
                                         gcfg_reg[g][DGP_GCFG_LO_DBL], drive_reg[2*g],
                                         latch_reg[2*g], live[2*g])};
            end
          end
        end
        DGP_REG_G1_CFG: rd_data_next = {11'h000, gcfg_reg[0]};
        DGP_REG_G2_CFG: rd_data_next = {11'h000, gcfg_reg[1]};
        DGP_REG_CNT_CFG: rd_data_next = {7'h00, ccfg_reg};
        DGP_REG_CNT1_LOAD: rd_data_next = load_reg[0];
        DGP_REG_CNT2_LOAD: rd_data_next = load_reg[1];
        DGP_REG_CNT3_LOAD: rd_data_next = load_reg[2];
        DGP_REG_STATUS: rd_data_next = {11'h000, ack_reg[1], ack_reg[0], c3flag_reg,
                                        ready_reg[1], ready_reg[0]};
        default: rd_data_next = 16'h0000;
      endcase
    end
  end

  // Bus registers; reset leaves every port a single-buffered read port
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (int g = 0; g < DGP_NUM_GRP; g++) begin
        gcfg_reg[g] <= DGP_GCFG_RST;
      end
      for (int c = 0; c < DGP_NUM_CNT; c++) begin
        load_reg[c] <= DGP_LOAD_RST;
      end
      ccfg_reg <= DGP_CCFG_RST;
      c3flag_reg <= 1'b0;
      rd_data_reg <= 16'h0000;
      bw16_reg <= 1'b0;
    end else begin
      gcfg_reg <= gcfg_next;
      load_reg <= load_next;
      ccfg_reg <= ccfg_next;
      c3flag_reg <= c3flag_next;
      rd_data_reg <= rd_data_next;
      bw16_reg <= bw16_next;
    end
  end

  // Handshake and data latches, each group on its own request only
  always_comb begin
    for (int g = 0; g < DGP_NUM_GRP; g++) begin
      logic enter_write;
      logic clr;
      logic [4:0] newcfg;
      newcfg = WR_DATA[DGP_GCFG_W-1:0];
      enter_write = wr_hit && (idx == (DGP_REG_G1_CFG + 5'(g))) && !grp_write[g]
                    && (newcfg[DGP_GCFG_LO_WRITE] || newcfg[DGP_GCFG_HI_WRITE]);
      clr = grp_write[g] ? data_wr[g] : data_rd[g];
      // Set wins so a request in the clearing cycle still flags ready
      ready_next[g] = req_evt[g] || enter_write || (ready_reg[g] && !clr);
      hs_next[g] = hs_reg[g];
      case (hs_reg[g])
        DGP_HS_WAIT: begin
          if (clr) begin
            hs_next[g] = DGP_HS_ACK;
          end
        end
        DGP_HS_ACK: begin
          if (req_evt[g]) begin
            hs_next[g] = DGP_HS_WAIT;
          end
        end
        default: hs_next[g] = DGP_HS_WAIT;
      endcase
      ack_next[g] = (hs_next[g] == DGP_HS_ACK);
      for (int p = 0; p < 2; p++) begin
        logic pw;
        logic pd;
        pw = gcfg_reg[g][DGP_GCFG_LO_WRITE + p];
        pd = gcfg_reg[g][DGP_GCFG_LO_DBL + p];
        stage_next[2*g+p] = stage_reg[2*g+p];
        drive_next[2*g+p] = drive_reg[2*g+p];
        latch_next[2*g+p] = latch_reg[2*g+p];
        if (data_wr[g] && pw) begin
          if (pd) begin
            stage_next[2*g+p] = WR_DATA[8*p +: 8];
          end else begin
            drive_next[2*g+p] = WR_DATA[8*p +: 8];
          end
        end
        // Copy takes the staging value held before any same-cycle write
        if (req_evt[g] && pd) begin
          if (pw) begin
            drive_next[2*g+p] = stage_reg[2*g+p];
          end else begin
            latch_next[2*g+p] = live[2*g+p];
          end
        end
      end
    end
  end

  // Handshake registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (int g = 0; g < DGP_NUM_GRP; g++) begin
        hs_reg[g] <= DGP_HS_WAIT;
        ready_reg[g] <= 1'b0;
        ack_reg[g] <= 1'b0;
        reqp_reg[g] <= 1'b0;
      end
      for (int p = 0; p < DGP_NUM_PORT; p++) begin
        stage_reg[p] <= 8'h00;
        drive_reg[p] <= 8'h00;
        latch_reg[p] <= 8'h00;
      end
    end else begin
      hs_reg <= hs_next;
      ready_reg <= ready_next;
      ack_reg <= ack_next;
      reqp_reg <= reqp_next;
      stage_reg <= stage_next;
      drive_reg <= drive_next;
      latch_reg <= latch_next;
    end
  end

  // Counter time base; pins arrive synchronous, so one sample plus its delay gives the edge
  assign cclk_tick = src_reg & ~srcp_reg;
  assign c3_tick = cclk_tick && (div_reg == DGP_CLK_DIV - 3'h1);
  assign tick[0] = ccfg_reg[DGP_CCFG_C1_DIRECT] ? cclk_tick : pulse_reg[2];
  assign tick[1] = ccfg_reg[DGP_CCFG_C2_DIRECT] ? cclk_tick : pulse_reg[2];
  assign tick[2] = c3_tick;

  // Counters; a stopped counter holds its value so software can resume it
  always_comb begin
    src_next = ccfg_reg[DGP_CCFG_SRC_TRIG] ? SHARED_TRIGGER_BUS_CLOCK
                                           : ONBOARD_OSCILLATOR;
    srcp_next = src_reg;
    div_next = div_reg;
    if (cclk_tick) begin
      div_next = c3_tick ? 3'h0 : div_reg + 3'h1;
    end
    for (int c = 0; c < DGP_NUM_CNT; c++) begin
      logic [16:0] step;
      step = cnt_step(cnt_reg[c], load_reg[c]);
      cnt_next[c] = cnt_reg[c];
      pulse_next[c] = 1'b0;
      if (tick[c] && ccfg_reg[DGP_CCFG_C1_RUN + c]) begin
        cnt_next[c] = step[15:0];
        pulse_next[c] = step[16];
      end
      // Reload write restarts the count; else a new period waits out the old one
      if (wr_hit && (idx == (DGP_REG_CNT1_LOAD + 5'(c)))) begin
        cnt_next[c] = WR_DATA;
      end
    end
  end

  // Counter registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      src_reg <= 1'b0;
      srcp_reg <= 1'b0;
      div_reg <= 3'h0;
      for (int c = 0; c < DGP_NUM_CNT; c++) begin
        cnt_reg[c] <= DGP_LOAD_RST;
        pulse_reg[c] <= 1'b0;
      end
    end else begin
      src_reg <= src_next;
      srcp_reg <= srcp_next;
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  // Outputs, all from flip-flops; enables follow each port's write bit
  assign RD_DATA = rd_data_reg;
  assign BUS_WIDTH_16 = bw16_reg;
  assign PORT_A_LINES_OUT = drive_reg[0];
  assign PORT_B_LINES_OUT = drive_reg[1];
  assign PORT_C_LINES_OUT = drive_reg[2];
  assign PORT_D_LINES_OUT = drive_reg[3];
  assign PORT_A_LINES_OE = {8{gcfg_reg[0][DGP_GCFG_LO_WRITE]}};
  assign PORT_B_LINES_OE = {8{gcfg_reg[0][DGP_GCFG_HI_WRITE]}};
  assign PORT_C_LINES_OE = {8{gcfg_reg[1][DGP_GCFG_LO_WRITE]}};
  assign PORT_D_LINES_OE = {8{gcfg_reg[1][DGP_GCFG_HI_WRITE]}};
  assign GROUP_ONE_ACK = ack_reg[0];
  assign GROUP_TWO_ACK = ack_reg[1];
  assign PERIODIC_IRQ = c3flag_reg;

endmodule

// file: dgp_io_sva.sv
`timescale 1ns/1ps
module dgp_io_chk (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [9:0] SA,
  input wire logic [4:0] BASE_ADDR,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [15:0] RD_DATA,
  input wire logic BUS_WIDTH_16,
  input wire logic [7:0] PORT_A_LINES_OUT,
  input wire logic [7:0] PORT_A_LINES_OE,
  input wire logic [7:0] PORT_B_LINES_OUT,
  input wire logic [7:0] PORT_B_LINES_OE,
  input wire logic [7:0] PORT_C_LINES_OUT,
  input wire logic [7:0] PORT_C_LINES_OE,
  input wire logic [7:0] PORT_D_LINES_OUT,
  input wire logic [7:0] PORT_D_LINES_OE,
  input wire logic GROUP_ONE_REQUEST,
  input wire logic GROUP_ONE_ACK,
  input wire logic PERIODIC_IRQ
);
  logic sel;
  logic [31:0] oe_all;
  logic oe_whole;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // Access aimed at this board
  assign sel = (WR_STB || RD_STB) && (SA[9:5] == BASE_ADDR);
  assign oe_all = {PORT_D_LINES_OE, PORT_C_LINES_OE, PORT_B_LINES_OE, PORT_A_LINES_OE};
  // Drivers switch a whole port at once, never single lines
  assign oe_whole = (oe_all[7:0] inside {8'h00, 8'hFF}) && (oe_all[15:8] inside {8'h00, 8'hFF})
    && (oe_all[23:16] inside {8'h00, 8'hFF}) && (oe_all[31:24] inside {8'h00, 8'hFF});
  width_ack_a: assert property (sel |=> BUS_WIDTH_16)
    else $error("width indication missing after selected access");
  bus_idle_a: assert property (!sel |=> !BUS_WIDTH_16)
    else $error("width indication without selected access");
  rd_quiet_a: assert property (!RD_STB |=> RD_DATA == 16'h0000)
    else $error("read data outside read answer cycle");
  oe_whole_a: assert property (oe_whole)
    else $error("partial port driver enable");
  reset_off_a: assert property ($fell(RESET) |-> !oe_all && !PORT_A_LINES_OUT)
    else $error("drivers active after reset");
  // Port A lines move only after a write or a request edge
  out_cause_a: assert property ($changed(PORT_A_LINES_OUT) |->
    $past(WR_STB) || $past(WR_STB, 2)
    || $past(GROUP_ONE_REQUEST) != $past(GROUP_ONE_REQUEST, 2)
    || $past(GROUP_ONE_REQUEST, 2) != $past(GROUP_ONE_REQUEST, 3)
    || $past(GROUP_ONE_REQUEST, 3) != $past(GROUP_ONE_REQUEST, 4))
    else $error("port output changed without cause");
  ack_cause_a: assert property ($rose(GROUP_ONE_ACK) |-> $past(WR_STB) || $past(RD_STB))
    else $error("acknowledge without host access");
  irq_clear_a: assert property ($fell(PERIODIC_IRQ) |-> $past(WR_STB) || $past(WR_STB, 2))
    else $error("periodic flag dropped without clear write");
  cover property ($rose(GROUP_ONE_ACK));
  cover property ($rose(PERIODIC_IRQ));
  cover property (sel ##1 BUS_WIDTH_16);
endmodule

bind dgp_io dgp_io_chk u_chk (.CLK(CLK), .RESET(RESET), .SA(SA), .BASE_ADDR(BASE_ADDR),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .BUS_WIDTH_16(BUS_WIDTH_16),
  .PORT_A_LINES_OUT(PORT_A_LINES_OUT), .PORT_A_LINES_OE(PORT_A_LINES_OE),
  .PORT_B_LINES_OUT(PORT_B_LINES_OUT), .PORT_B_LINES_OE(PORT_B_LINES_OE),
  .PORT_C_LINES_OUT(PORT_C_LINES_OUT), .PORT_C_LINES_OE(PORT_C_LINES_OE),
  .PORT_D_LINES_OUT(PORT_D_LINES_OUT), .PORT_D_LINES_OE(PORT_D_LINES_OE),
  .GROUP_ONE_REQUEST(GROUP_ONE_REQUEST), .GROUP_ONE_ACK(GROUP_ONE_ACK),
  .PERIODIC_IRQ(PERIODIC_IRQ));

// file: dgp_ext_dev.sv
`timescale 1ns/1ps
module dgp_ext_dev (
  input wire logic clk,
  input wire logic [31:0] ext,
  input wire logic [31:0] dev_out,
  input wire logic [31:0] dev_oe,
  input wire logic [1:0] go,
  output logic [31:0] lines,
  output logic [1:0] req
);
  logic [3:0] hold_reg [2];
  // Far side backs off wherever the block drives
  assign lines = (dev_oe & dev_out) | (~dev_oe & ext);
  assign req = {hold_reg[1] != 4'h0, hold_reg[0] != 4'h0};
  initial begin
    hold_reg[0] = 4'h0;
    hold_reg[1] = 4'h0;
  end
  // Request held ten cycles, well above the minimum pulse width
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (go[i]) begin
        hold_reg[i] <= 4'hA;
      end else if (hold_reg[i] != 4'h0) begin
        hold_reg[i] <= hold_reg[i] - 4'h1;
      end
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
  import dgp_pkg::*;
  logic clk, reset, wr_stb, rd_stb, osc, trig_clk, osc_en, trig_en, bw16, irq;
  logic [9:0] sa;
  logic [4:0] base;
  logic [15:0] wr_data, rd_data, v, w;
  logic [31:0] ext, lines, dout, doe, lat;
  logic [1:0] go, req, ack;
  logic [2:0] oc;
  int n_mismatch, n_tests, seed, k;
  time t0;
  dgp_io dut (.CLK(clk), .RESET(reset), .SA(sa), .BASE_ADDR(base), .WR_DATA(wr_data),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .BUS_WIDTH_16(bw16),
    .PORT_A_LINES_IN(lines[7:0]), .PORT_A_LINES_OUT(dout[7:0]), .PORT_A_LINES_OE(doe[7:0]),
    .PORT_B_LINES_IN(lines[15:8]), .PORT_B_LINES_OUT(dout[15:8]), .PORT_B_LINES_OE(doe[15:8]),
    .PORT_C_LINES_IN(lines[23:16]), .PORT_C_LINES_OUT(dout[23:16]),
    .PORT_C_LINES_OE(doe[23:16]), .PORT_D_LINES_IN(lines[31:24]),
    .PORT_D_LINES_OUT(dout[31:24]), .PORT_D_LINES_OE(doe[31:24]),
    .GROUP_ONE_REQUEST(req[0]), .GROUP_TWO_REQUEST(req[1]), .GROUP_ONE_ACK(ack[0]),
    .GROUP_TWO_ACK(ack[1]), .ONBOARD_OSCILLATOR(osc), .SHARED_TRIGGER_BUS_CLOCK(trig_clk),
    .PERIODIC_IRQ(irq));
  dgp_ext_dev far_dev (.clk(clk), .ext(ext), .dev_out(dout), .dev_oe(doe), .go(go),
    .lines(lines), .req(req));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // 10 MHz counter clock sources, toggled every fifth edge
  always @(posedge clk) begin
    oc <= (oc == 3'h4) ? 3'h0 : oc + 3'h1;
    if (oc == 3'h4) begin
      osc <= osc ^ osc_en;
      trig_clk <= trig_clk ^ trig_en;
    end
  end
  task wr(input logic [4:0] idx, input logic [15:0] d);
    @(posedge clk);
    sa <= {base, idx};
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // Read data is taken in the single cycle it stands
  task rchk(input string nm, input logic [9:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    sa <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    w = rd_data;
    `CHK(nm, e, w & m)
    `CHK("width", a[9:5] == base, bw16)
  endtask
  task pulse(input logic [1:0] g);
    @(posedge clk);
    go <= g;
    @(posedge clk);
    go <= 2'b00;
    repeat (15) @(posedge clk);
    #1;
  endtask
  task wait_irq;
    k = 0;
    // Let a clear launched at this edge settle before looking
    #1;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  // Period of the flag: four counter-three ticks of five source edges each
  task period_chk(input string nm);
    wr(DGP_REG_STATUS, 16'h0004);
    wait_irq;
    t0 = $time;
    wr(DGP_REG_STATUS, 16'h0004);
    @(posedge clk);
    #1;
    `CHK("flag clear", 1'b0, irq)
    wait_irq;
    t0 = $time - t0;
    `CHK(nm, 1'b1, t0 > DGP_CLK_DIV * 400 - 21 && t0 < DGP_CLK_DIV * 400 + 21)
  endtask
  task print_verdict;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the expected thousand or so cycles
  initial begin
    #500000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    seed = 32'hc95a;
    {reset, wr_stb, rd_stb, sa, wr_data, base, ext, go, oc} = {1'b1, 28'h0, 5'h1F, 37'h0};
    {osc, trig_clk, osc_en, trig_en, n_mismatch, n_tests} = {4'b0010, 64'h0};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("drivers", 32'h0, doe)
    `CHK("outputs", 32'h0, dout)
    // Live reads at the top base and then random bases
    repeat (4) begin
      rchk("g1 live", {base, DGP_REG_G1_DATA}, 16'hFFFF, ext[15:0]);
      rchk("g2 live", {base, DGP_REG_G2_DATA}, 16'hFFFF, ext[31:16]);
      rchk("unselected", {~base, DGP_REG_G1_DATA}, 16'hFFFF, 16'h0000);
      rchk("unmapped", {base, 5'h1F}, 16'hFFFF, 16'h0000);
      @(posedge clk);
      base <= 5'($random(seed));
      ext <= $random(seed);
      #1;
    end
    v = 16'($random(seed));
    wr(DGP_REG_G1_CFG, 16'h0001);
    wr(DGP_REG_G1_DATA, v);
    @(posedge clk);
    #1;
    `CHK("oe a only", 32'h000000FF, doe)
    `CHK("out a", v[7:0], dout[7:0])
    rchk("mixed", {base, DGP_REG_G1_DATA}, 16'hFFFF, {ext[15:8], v[7:0]});
    wr(DGP_REG_G1_CFG, 16'h0003);
    wr(DGP_REG_G1_DATA, v);
    @(posedge clk);
    #1;
    `CHK("oe g1", 32'h0000FFFF, doe)
    rchk("g1 drive", {base, DGP_REG_G1_DATA}, 16'hFFFF, v);
    rchk("g2 input", {base, DGP_REG_G2_DATA}, 16'hFFFF, ext[31:16]);
    // Double-buffered output keeps old value until request
    lat = $random(seed);
    wr(DGP_REG_G1_CFG, 16'h000F);
    wr(DGP_REG_G1_DATA, lat[15:0]);
    repeat (3) @(posedge clk);
    #1;
    `CHK("staged", v, dout[15:0])
    `CHK("ack1 up", 1'b1, ack[0])
    rchk("ready1 low", {base, DGP_REG_STATUS}, 16'h0001, 16'h0000);
    pulse(2'b01);
    `CHK("copied", lat[15:0], dout[15:0])
    `CHK("ack1 down", 1'b0, ack[0])
    rchk("ready1 high", {base, DGP_REG_STATUS}, 16'h0001, 16'h0001);
    // Both groups take a request in the same cycle
    wr(DGP_REG_G2_CFG, 16'h000C);
    wr(DGP_REG_G1_DATA, lat[31:16]);
    @(posedge clk);
    ext <= $random(seed);
    #1;
    v = ext[31:16];
    pulse(2'b11);
    `CHK("both", lat[31:16], dout[15:0])
    @(posedge clk);
    ext <= ~ext;
    rchk("ready2 high", {base, DGP_REG_STATUS}, 16'h0002, 16'h0002);
    rchk("latched", {base, DGP_REG_G2_DATA}, 16'hFFFF, v);
    `CHK("ack2 up", 1'b1, ack[1])
    rchk("ready2 low", {base, DGP_REG_STATUS}, 16'h0002, 16'h0000);
    wr(DGP_REG_CNT3_LOAD, 16'h0003);
    wr(DGP_REG_CNT_CFG, 16'h0120);
    period_chk("osc period");
    osc_en <= 1'b0;
    trig_en <= 1'b1;
    wr(DGP_REG_CNT_CFG, 16'h0121);
    period_chk("trig period");
    // Counter two paces group two straight from the counter clock
    wr(DGP_REG_CNT2_LOAD, 16'h0003);
    wr(DGP_REG_CNT_CFG, 16'h0195);
    repeat (60) @(posedge clk);
    rchk("ctr2 request", {base, DGP_REG_STATUS}, 16'h0002, 16'h0002);
    print_verdict;
  end
endmodule
